// ### verification/tcu_core_model.sv
// processor core model answering interrupt requests
`timescale 1ns/1ps
module tcu_core_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // bench control
   input  wire logic       ack_en,
   input  wire logic [3:0] dly,
   // interrupt lines
   input  wire logic       capture_irq,
   input  wire logic       compare_a_irq,
   input  wire logic       compare_b_irq,
   output logic [2:0]      irq_ack
);
   initial begin
      irq_ack = 3'h0;
      forever begin
         @(posedge clk);
         if (ack_en && !reset && (capture_irq || compare_a_irq || compare_b_irq)) begin
            repeat (dly) @(posedge clk);
            irq_ack <= {compare_b_irq, compare_a_irq, capture_irq};
            @(posedge clk);
            irq_ack <= 3'h0;
            repeat (3) @(posedge clk);
         end
      end
   end
endmodule : tcu_core_model

// ### verification/timer_capture_compare_unit_bench.sv
// self-checking bench for the capture and compare unit
`timescale 1ns/1ps
module timer_capture_compare_unit_bench;
   logic        clk = 1'b0, reset = 1'b1, tick = 1'b0, ack_en = 1'b0;
   logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [4:0]  src = 5'h00;
   logic [3:0]  dly = 4'h0;
   logic        awr, wrd, bv, arr, rv, cirq, airq, birq, irq;
   logic [1:0]  br, rr;
   logic [2:0]  ack;
   logic [31:0] rdat;
   int          n_errors = 0, compares = 0, cyc = 0, seed = 53751;
   int          m_cnt = 0, m_a = 0, m_b = 0, m_cap = 0, m_w = 0, m_blk = 0, m_fl = 0;

   tcu_top #(.TIMER_INST(1'b1)) dut (
      .clk(clk), .reset(reset),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .timer_tick(tick), .instant_conv_done_event(src[0]), .accum_conv_done_event(src[1]),
      .capture_port_pin(src[2]), .lin_rx_done_event(src[3]), .lin_tx_done_event(src[4]),
      .irq_ack(ack), .capture_irq(cirq), .compare_a_irq(airq), .compare_b_irq(birq),
      .irq(irq));

   tcu_core_model core (
      .clk(clk), .reset(reset), .ack_en(ack_en), .dly(dly), .capture_irq(cirq),
      .compare_a_irq(airq), .compare_b_irq(birq), .irq_ack(ack));

   // instance zero twin, same stimulus, only its capture request is watched
   logic        cirq0;
   tcu_top #(.TIMER_INST(1'b0)) dut_zero (
      .clk(clk), .reset(reset),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(),
      .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(),
      .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rry),
      .timer_tick(tick), .instant_conv_done_event(src[0]), .accum_conv_done_event(src[1]),
      .capture_port_pin(src[2]), .lin_rx_done_event(src[3]), .lin_tx_done_event(src[4]),
      .irq_ack(ack), .capture_irq(cirq0), .compare_a_irq(), .compare_b_irq(),
      .irq());

   always #5 clk = ~clk;

   task automatic end_sim;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         $display("[FAIL] %0t timeout", $time);
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      forever begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
         if (bv) begin
            bry <= 1'b0;
            chk(32'(br), 32'(er), "bresp");
            break;
         end
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      forever begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
         if (rv) begin
            rry <= 1'b0;
            chk(32'(rr), 32'(er), "rresp");
            chk(rdat, exp, "rdata");
            break;
         end
      end
   endtask : rd

   function automatic logic [31:0] ctl(input int w, input int cp, input int f, input int e,
                                       input int s);
      return 32'((w << tcu_pkg::CTRL_WIDTH) | (cp << tcu_pkg::CTRL_CAPEN) |
                 (f << tcu_pkg::CTRL_FILT) | (e << tcu_pkg::CTRL_EDGE) |
                 (s << tcu_pkg::CTRL_SRC_LO));
   endfunction : ctl

   // count write; next tick is blocked
   task automatic setcnt(input int v);
      wr(tcu_pkg::OFF_COUNT, 32'(v), tcu_pkg::RESP_OKAY);
      m_cnt = v;
      m_blk = 1;
   endtask : setcnt

   // timer ticks with reference compare
   task automatic tk(input int n);
      repeat (n) begin
         @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
         if (!m_blk && m_w == 1 && m_cnt == (m_b << 8 | m_a)) m_fl |= 1 << tcu_pkg::FLG_CMPA;
         if (!m_blk && m_w == 0 && m_cnt == m_a) m_fl |= 1 << tcu_pkg::FLG_CMPA;
         if (!m_blk && m_w == 0 && m_cnt == m_b) m_fl |= 1 << tcu_pkg::FLG_CMPB;
         m_blk = 0;
         m_cnt = (m_cnt + 1) & (m_w == 1 ? 32'hFFFF : 32'hFF);
      end
   endtask : tk

   task automatic pulse(input int i, input int len);
      @(posedge clk);
      src[i] <= 1'b1;
      repeat (len) @(posedge clk);
      src[i] <= 1'b0;
      repeat (10) @(posedge clk);
   endtask : pulse

   task automatic lvl(input int i, input logic val);
      @(posedge clk);
      src[i] <= val;
      repeat (10) @(posedge clk);
   endtask : lvl

   initial begin
      int v;
      int hit;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rd(tcu_pkg::OFF_CTRL, 32'h0, tcu_pkg::RESP_OKAY);
      rd(tcu_pkg::OFF_STATUS, 32'h0, tcu_pkg::RESP_OKAY);
      rd(8'h1C, 32'h0, tcu_pkg::RESP_SLVERR);
      wr(tcu_pkg::OFF_CAPTURE, 32'h5, tcu_pkg::RESP_SLVERR);
      $display("test reset done");
      wr(tcu_pkg::OFF_MASK, 32'h1, tcu_pkg::RESP_OKAY);
      for (int c = 0; c < 4; c++) begin
         for (int s = 0; s < 5; s++) begin
            wr(tcu_pkg::OFF_CTRL, ctl(0, 1, 0, 1, c), tcu_pkg::RESP_OKAY);
            v = $random(seed) & 8'hFF;
            setcnt(v);
            pulse(s, 3);
            hit = (c < 3 && s == c + 2) ? 1 : 0;
            if (hit == 1) m_cap = v;
            rd(tcu_pkg::OFF_STATUS, 32'(hit), tcu_pkg::RESP_OKAY);
            chk(32'(cirq), 32'(hit), "capture irq");
            chk(32'(cirq0), 32'((c < 2 && s == c) ? 1 : 0), "instance zero capture irq");
            rd(tcu_pkg::OFF_CAPTURE, 32'(m_cap), tcu_pkg::RESP_OKAY);
            wr(tcu_pkg::OFF_STATUS, 32'h1, tcu_pkg::RESP_OKAY);
         end
      end
      $display("test source select done");
      wr(tcu_pkg::OFF_CTRL, ctl(0, 1, 0, 1, 0), tcu_pkg::RESP_OKAY);
      v = $random(seed) & 8'hFF;
      setcnt(v);
      lvl(2, 1'b1);
      rd(tcu_pkg::OFF_CAPTURE, 32'(v), tcu_pkg::RESP_OKAY);
      wr(tcu_pkg::OFF_CTRL, ctl(0, 1, 0, 0, 0), tcu_pkg::RESP_OKAY);
      wr(tcu_pkg::OFF_STATUS, 32'h1, tcu_pkg::RESP_OKAY);
      rd(tcu_pkg::OFF_STATUS, 32'h0, tcu_pkg::RESP_OKAY);
      v = $random(seed) & 8'hFF;
      setcnt(v);
      lvl(2, 1'b0);
      rd(tcu_pkg::OFF_CAPTURE, 32'(v), tcu_pkg::RESP_OKAY);
      wr(tcu_pkg::OFF_STATUS, 32'h1, tcu_pkg::RESP_OKAY);
      lvl(2, 1'b1);
      rd(tcu_pkg::OFF_STATUS, 32'h0, tcu_pkg::RESP_OKAY);
      lvl(2, 1'b0);
      $display("test edge select done");
      wr(tcu_pkg::OFF_CTRL, ctl(0, 1, 1, 1, 0), tcu_pkg::RESP_OKAY);
      wr(tcu_pkg::OFF_STATUS, 32'h1, tcu_pkg::RESP_OKAY);
      pulse(2, 3);
      rd(tcu_pkg::OFF_STATUS, 32'h0, tcu_pkg::RESP_OKAY);
      pulse(2, 6);
      rd(tcu_pkg::OFF_STATUS, 32'h1, tcu_pkg::RESP_OKAY);
      wr(tcu_pkg::OFF_CTRL, ctl(1, 1, 0, 1, 0), tcu_pkg::RESP_OKAY);
      v = $random(seed) & 16'hFFFF;
      setcnt(v);
      pulse(2, 3);
      rd(tcu_pkg::OFF_CAPTURE, 32'(v), tcu_pkg::RESP_OKAY);
      rd(tcu_pkg::OFF_CMPA, 32'(v & 8'hFF), tcu_pkg::RESP_OKAY);
      rd(tcu_pkg::OFF_CMPB, 32'(v >> 8), tcu_pkg::RESP_OKAY);
      $display("test filter and wide capture done");
      wr(tcu_pkg::OFF_MASK, 32'h0, tcu_pkg::RESP_OKAY);
      for (int i = 0; i < 12; i++) begin
         m_w = i & 1;
         v = $random(seed) & 8'h7F;
         m_a = (i < 2) ? v : (v + ($random(seed) & 3));
         m_b = (m_w == 1) ? 0 : (v + ($random(seed) & 7));
         wr(tcu_pkg::OFF_CTRL, ctl(m_w, 0, 0, 0, 0), tcu_pkg::RESP_OKAY);
         wr(tcu_pkg::OFF_CMPA, 32'(m_a), tcu_pkg::RESP_OKAY);
         wr(tcu_pkg::OFF_CMPB, 32'(m_b), tcu_pkg::RESP_OKAY);
         wr(tcu_pkg::OFF_STATUS, 32'h7, tcu_pkg::RESP_OKAY);
         m_fl = 0;
         setcnt(v);
         tk(1 + ($random(seed) & 7));
         rd(tcu_pkg::OFF_STATUS, 32'(m_fl), tcu_pkg::RESP_OKAY);
         rd(tcu_pkg::OFF_COUNT, 32'(m_cnt), tcu_pkg::RESP_OKAY);
         wr(tcu_pkg::OFF_STATUS, 32'(m_fl), tcu_pkg::RESP_OKAY);
         rd(tcu_pkg::OFF_STATUS, 32'h0, tcu_pkg::RESP_OKAY);
      end
      $display("test compare done");
      m_w = 0;
      wr(tcu_pkg::OFF_CTRL, 32'h0, tcu_pkg::RESP_OKAY);
      wr(tcu_pkg::OFF_CMPA, 32'h3, tcu_pkg::RESP_OKAY);
      wr(tcu_pkg::OFF_CMPB, 32'h80, tcu_pkg::RESP_OKAY);
      setcnt(1);
      tk(3);
      rd(tcu_pkg::OFF_STATUS, 32'h2, tcu_pkg::RESP_OKAY);
      chk(32'(irq), 32'h0, "masked irq");
      wr(tcu_pkg::OFF_MASK, 32'h2, tcu_pkg::RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(32'(airq), 32'h1, "compare a irq");
      chk(32'(irq), 32'h1, "irq");
      m_a = 3;
      m_b = m_cnt;
      m_fl = 0;
      wr(tcu_pkg::OFF_CMPB, 32'(m_b), tcu_pkg::RESP_OKAY);
      wr(tcu_pkg::OFF_MASK, 32'h6, tcu_pkg::RESP_OKAY);
      tk(1);
      repeat (2) @(posedge clk);
      chk(32'(birq), 32'(m_fl >> tcu_pkg::FLG_CMPB), "compare b irq");
      @(posedge clk);
      dly <= 4'($random(seed) & 7);
      ack_en <= 1'b1;
      repeat (20) @(posedge clk);
      rd(tcu_pkg::OFF_STATUS, 32'h0, tcu_pkg::RESP_OKAY);
      chk(32'(irq), 32'h0, "irq after ack");
      ack_en <= 1'b0;
      $display("test interrupt done");
      end_sim();
   end
endmodule : timer_capture_compare_unit_bench

// ### verilog/tcu_pkg.sv
// constants for the timer capture and compare unit
package tcu_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_COUNT   = 8'h04;
   localparam logic [7:0] OFF_CMPA    = 8'h08;
   localparam logic [7:0] OFF_CMPB    = 8'h0C;
   localparam logic [7:0] OFF_CAPTURE = 8'h10;
   localparam logic [7:0] OFF_STATUS  = 8'h14;
   localparam logic [7:0] OFF_MASK    = 8'h18;
   // control fields
   localparam int CTRL_WIDTH  = 0;
   localparam int CTRL_CAPEN  = 1;
   localparam int CTRL_FILT   = 2;
   localparam int CTRL_EDGE   = 3;
   localparam int CTRL_SRC_LO = 4;
   localparam int CTRL_BITS   = 6;
   // status and mask fields
   localparam int FLG_CAP  = 0;
   localparam int FLG_CMPA = 1;
   localparam int FLG_CMPB = 2;
   localparam int FLG_BITS = 3;
   // source select codes
   localparam logic [1:0] SRC_00 = 2'h0;
   localparam logic [1:0] SRC_01 = 2'h1;
   localparam logic [1:0] SRC_10 = 2'h2;
   // filter sample depth
   localparam int FILT_SAMPLES = 4;
   // reset values and bus answers
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tcu_pkg

// ### verilog/tcu_top.sv
// capture and compare unit with axi4-lite register slave
// Notes on behaviour
// - new capture overwrites unread capture value
// - capture flag cleared by writing one
// - instance zero sources: instant, accumulated conversion
// - instance one sources: pin, rx, tx
// - internal source capture also raises capture request
// - counter compared against both registers; a sets its flag only with capture off
// - compare flag set on following tick
// - 8-bit sets a or b; 16-bit only a
// - compare flags cleared by ack or one
// - counter write blocks match next tick
// - system clock only, tick is enable
// - capture copies count, sets flag same cycle
// - edge select zero falling, one rising
// - filter needs four equal samples
// - 16-bit capture uses a low, b high
`timescale 1ns/1ps
module tcu_top #(
   parameter bit TIMER_INST = 1'b0
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // axi4-lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // timer tick and capture sources
   input  wire logic        timer_tick,
   input  wire logic        instant_conv_done_event,
   input  wire logic        accum_conv_done_event,
   input  wire logic        capture_port_pin,
   input  wire logic        lin_rx_done_event,
   input  wire logic        lin_tx_done_event,
   // interrupt controller
   input  wire logic [2:0]  irq_ack,
   output logic             capture_irq,
   output logic             compare_a_irq,
   output logic             compare_b_irq,
   output logic             irq
);
   // core state
   logic [5:0]  ctrl, next_ctrl;
   logic [15:0] count_value, next_count_value;
   logic [7:0]  compare_reg_a, next_compare_reg_a, compare_reg_b, next_compare_reg_b;
   logic [2:0]  flags, next_flags, mask, next_mask;
   logic [3:0]  samp, next_samp, irqs, next_irqs;
   logic        block, next_block, filt, next_filt, src_q, next_src_q, prev, next_prev;
   // bus state
   logic        aw_hold, next_aw_hold, w_hold, next_w_hold, awready, next_awready;
   logic        wready, next_wready, bvalid, next_bvalid, arready, next_arready;
   logic        rvalid, next_rvalid;
   logic [7:0]  waddr, next_waddr;
   logic [31:0] wdata, next_wdata, rdata, next_rdata;
   logic [3:0]  wstrb, next_wstrb;
   logic [1:0]  bresp, next_bresp, rresp, next_rresp;
   // combinational helpers
   logic        do_write, src_raw, cap_in, cap_fire, width16;
   logic        match_a, match_b, en_a, en_b;
   logic [15:0] lane_mask;
   logic [2:0]  clr, set;

   assign width16   = ctrl[tcu_pkg::CTRL_WIDTH];
   assign do_write  = aw_hold && w_hold && !bvalid;
   assign lane_mask = {{8{wstrb[1]}}, {8{wstrb[0]}}};

   // source select per instance
   always_comb begin
      src_raw = 1'b0;
      if (TIMER_INST == 1'b0) begin
         unique case (ctrl[tcu_pkg::CTRL_SRC_LO +: 2])
            tcu_pkg::SRC_00: src_raw = instant_conv_done_event;
            tcu_pkg::SRC_01: src_raw = accum_conv_done_event;
            default:         src_raw = 1'b0;
         endcase
      end else begin
         unique case (ctrl[tcu_pkg::CTRL_SRC_LO +: 2])
            tcu_pkg::SRC_00: src_raw = capture_port_pin;
            tcu_pkg::SRC_01: src_raw = lin_rx_done_event;
            tcu_pkg::SRC_10: src_raw = lin_tx_done_event;
            default:         src_raw = 1'b0;
         endcase
      end
   end

   // filtered or direct input, edge detect
   assign cap_in   = ctrl[tcu_pkg::CTRL_FILT] ? filt : src_q;
   assign cap_fire = ctrl[tcu_pkg::CTRL_CAPEN] &&
                     (ctrl[tcu_pkg::CTRL_EDGE] ? (cap_in && !prev) : (!cap_in && prev));

   // comparators run every cycle
   assign match_a = width16 ? (count_value == {compare_reg_b, compare_reg_a})
                            : (count_value[7:0] == compare_reg_a);
   assign match_b = count_value[7:0] == compare_reg_b;
   assign en_a    = !ctrl[tcu_pkg::CTRL_CAPEN];
   assign en_b    = !width16;

   // core next state
   always_comb begin
      next_ctrl          = ctrl;
      next_count_value   = count_value;
      next_compare_reg_a = compare_reg_a;
      next_compare_reg_b = compare_reg_b;
      next_mask          = mask;
      next_block         = block;
      clr                = irq_ack;
      set                = 3'h0;
      next_samp          = {samp[2:0], src_raw};
      next_src_q         = src_raw;
      next_prev          = cap_in;
      next_filt          = (&samp) ? 1'b1 : ((~|samp) ? 1'b0 : filt);
      if (timer_tick) begin
         next_count_value = width16 ? count_value + 16'h0001
                                    : {8'h00, count_value[7:0] + 8'h01};
         set[tcu_pkg::FLG_CMPA] = match_a && en_a && !block;
         set[tcu_pkg::FLG_CMPB] = match_b && en_b && !block;
         next_block = 1'b0;
      end
      if (do_write) begin
         unique case (waddr)
            tcu_pkg::OFF_CTRL:
               if (wstrb[0]) begin
                  next_ctrl = wdata[5:0];
               end
            tcu_pkg::OFF_COUNT: begin
               next_count_value = (wdata[15:0] & lane_mask) | (count_value & ~lane_mask);
               if (!width16) begin
                  next_count_value[15:8] = 8'h00;
               end
               next_block = 1'b1;
            end
            tcu_pkg::OFF_CMPA:
               if (wstrb[0]) begin
                  next_compare_reg_a = wdata[7:0];
               end
            tcu_pkg::OFF_CMPB:
               if (wstrb[0]) begin
                  next_compare_reg_b = wdata[7:0];
               end
            tcu_pkg::OFF_STATUS:
               if (wstrb[0]) begin
                  clr = clr | wdata[2:0];
               end
            tcu_pkg::OFF_MASK:
               if (wstrb[0]) begin
                  next_mask = wdata[2:0];
               end
            default: ;
         endcase
      end
      if (cap_fire) begin
         next_compare_reg_a = count_value[7:0];
         if (width16) begin
            next_compare_reg_b = count_value[15:8];
         end
         set[tcu_pkg::FLG_CAP] = 1'b1;
      end
      next_flags = (flags & ~clr) | set;
      next_irqs  = {|(next_flags & next_mask), next_flags & next_mask};
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl          <= tcu_pkg::CTRL_RESET;
         count_value   <= 16'h0000;
         compare_reg_a <= 8'h00;
         compare_reg_b <= 8'h00;
         flags         <= 3'h0;
         mask          <= 3'h0;
         block         <= 1'b0;
         samp          <= 4'h0;
         filt          <= 1'b0;
         src_q         <= 1'b0;
         prev          <= 1'b0;
         irqs          <= 4'h0;
      end else begin
         ctrl          <= next_ctrl;
         count_value   <= next_count_value;
         compare_reg_a <= next_compare_reg_a;
         compare_reg_b <= next_compare_reg_b;
         flags         <= next_flags;
         mask          <= next_mask;
         block         <= next_block;
         samp          <= next_samp;
         filt          <= next_filt;
         src_q         <= next_src_q;
         prev          <= next_prev;
         irqs          <= next_irqs;
      end
   end

   assign capture_irq   = irqs[tcu_pkg::FLG_CAP];
   assign compare_a_irq = irqs[tcu_pkg::FLG_CMPA];
   assign compare_b_irq = irqs[tcu_pkg::FLG_CMPB];
   assign irq           = irqs[3];

   // bus next state
   always_comb begin
      next_aw_hold = aw_hold;
      next_w_hold  = w_hold;
      next_waddr   = waddr;
      next_wdata   = wdata;
      next_wstrb   = wstrb;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rresp   = rresp;
      next_rdata   = rdata;
      if (s_axi_awvalid && awready) begin
         next_aw_hold = 1'b1;
         next_waddr   = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready) begin
         next_w_hold = 1'b1;
         next_wdata  = s_axi_wdata;
         next_wstrb  = s_axi_wstrb;
      end
      if (do_write) begin
         next_aw_hold = 1'b0;
         next_w_hold  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = (waddr == tcu_pkg::OFF_CAPTURE || waddr > tcu_pkg::OFF_MASK ||
                         waddr[1:0] != 2'h0) ? tcu_pkg::RESP_SLVERR : tcu_pkg::RESP_OKAY;
      end else if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp  = tcu_pkg::RESP_OKAY;
         next_rdata  = 32'h0000_0000;
         unique case (s_axi_araddr)
            tcu_pkg::OFF_CTRL:    next_rdata[5:0]  = ctrl;
            tcu_pkg::OFF_COUNT:   next_rdata[15:0] = count_value;
            tcu_pkg::OFF_CMPA:    next_rdata[7:0]  = compare_reg_a;
            tcu_pkg::OFF_CMPB:    next_rdata[7:0]  = compare_reg_b;
            tcu_pkg::OFF_CAPTURE: next_rdata[15:0] = width16 ? {compare_reg_b, compare_reg_a}
                                                             : {8'h00, compare_reg_a};
            tcu_pkg::OFF_STATUS:  next_rdata[2:0]  = flags;
            tcu_pkg::OFF_MASK:    next_rdata[2:0]  = mask;
            default:              next_rresp       = tcu_pkg::RESP_SLVERR;
         endcase
      end
      next_awready = !next_aw_hold && !next_bvalid;
      next_wready  = !next_w_hold && !next_bvalid;
      next_arready = !next_rvalid;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         aw_hold <= 1'b0;
         w_hold  <= 1'b0;
         waddr   <= 8'h00;
         wdata   <= 32'h0000_0000;
         wstrb   <= 4'h0;
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= tcu_pkg::RESP_OKAY;
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rresp   <= tcu_pkg::RESP_OKAY;
         rdata   <= 32'h0000_0000;
      end else begin
         aw_hold <= next_aw_hold;
         w_hold  <= next_w_hold;
         waddr   <= next_waddr;
         wdata   <= next_wdata;
         wstrb   <= next_wstrb;
         awready <= next_awready;
         wready  <= next_wready;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         arready <= next_arready;
         rvalid  <= next_rvalid;
         rresp   <= next_rresp;
         rdata   <= next_rdata;
      end
   end

   assign s_axi_awready = awready;
   assign s_axi_wready  = wready;
   assign s_axi_bvalid  = bvalid;
   assign s_axi_bresp   = bresp;
   assign s_axi_arready = arready;
   assign s_axi_rvalid  = rvalid;
   assign s_axi_rresp   = rresp;
   assign s_axi_rdata   = rdata;

   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   cap_sets_flag_a: assert property (cap_fire |=> flags[tcu_pkg::FLG_CAP])
      else $error("capture did not set capture flag");
   cap_stores_count_a: assert property (cap_fire |=> compare_reg_a == $past(count_value[7:0]))
      else $error("capture value not stored");
   write_blocks_a: assert property (timer_tick && block && !flags[tcu_pkg::FLG_CMPA] |=>
      !flags[tcu_pkg::FLG_CMPA])
      else $error("match not blocked after counter write");
   match_sets_a: assert property (timer_tick && match_a && en_a && !block |=>
      flags[tcu_pkg::FLG_CMPA])
      else $error("compare a flag not set on tick");
   flag_b_cause_a: assert property ($rose(flags[tcu_pkg::FLG_CMPB]) |->
      $past(timer_tick && match_b && !width16))
      else $error("compare b flag set without cause");
   ack_clears_a: assert property (irq_ack[tcu_pkg::FLG_CMPA] && !set[tcu_pkg::FLG_CMPA] |=>
      !flags[tcu_pkg::FLG_CMPA])
      else $error("acknowledge did not clear compare a flag");
   cap_irq_out_a: assert property (cap_fire && mask[tcu_pkg::FLG_CAP] &&
      !(do_write && waddr == tcu_pkg::OFF_MASK) |=> capture_irq && irq)
      else $error("capture interrupt not raised");
   filter_stable_a: assert property ($changed(filt) |-> $past(samp == 4'hF || samp == 4'h0))
      else $error("filter output changed without four equal samples");
   edge_kind_a: assert property (cap_fire |-> cap_in == ctrl[tcu_pkg::CTRL_EDGE] &&
      $past(cap_in) != ctrl[tcu_pkg::CTRL_EDGE])
      else $error("capture on wrong edge");
endmodule : tcu_top
